// ==== cotm_consts.svh ====
// constants for the converter on/off, trim and margin control block
`ifndef COTM_CONSTS_SVH
`define COTM_CONSTS_SVH
// command codes seen on the decoded command port
`define COTM_CMD_OPERATION 8'h01
`define COTM_CMD_ONOFF 8'h02
`define COTM_CMD_CLEAR 8'h03
`define COTM_CMD_RISE 8'h61
`define COTM_CMD_TRIM 8'hD4
`define COTM_CMD_MHIGH 8'hD5
`define COTM_CMD_MLOW 8'hD6
`define COTM_CMD_STATUS 8'h78
`define COTM_CMD_STCML 8'h7E
// reset values and the on/off configuration write mask
`define COTM_OP_RST 8'h80
`define COTM_CFG_RST 5'h14
`define COTM_CFG_WMASK 5'h1E
// operation byte fields
`define COTM_OP_ON 7
`define COTM_OP_MRG_HI 5
`define COTM_OP_MRG_LO 2
`define COTM_MRG_LOW_A 4'h5
`define COTM_MRG_LOW_B 4'h6
`define COTM_MRG_HIGH_A 4'h9
`define COTM_MRG_HIGH_B 4'hA
// on/off configuration fields
`define COTM_CFG_PWRUP 4
`define COTM_CFG_CMDRSP 3
`define COTM_CFG_PINRSP 2
`define COTM_CFG_PINPOL 1
`define COTM_CFG_PINOFF 0
// linear word layout: exponent above an 11-bit mantissa
`define COTM_EXP_HI 15
`define COTM_EXP_LO 11
`define COTM_MANT_HI 10
`define COTM_EXP_RISE 5'h1C
`define COTM_EXP_M9 5'h17
`define COTM_STEP_SIGN 14
// rise-time mantissas, 0.6 ms up to 9.0 ms
`define COTM_RISE_M0 11'h00A
`define COTM_RISE_M1 11'h00E
`define COTM_RISE_M2 11'h013
`define COTM_RISE_M3 11'h01D
`define COTM_RISE_M4 11'h02B
`define COTM_RISE_M5 11'h043
`define COTM_RISE_M6 11'h060
`define COTM_RISE_M7 11'h090
// limits in steps of 2^-9 V
`define COTM_TRIM_MIN 16'shFFC3
`define COTM_TRIM_MIN_LV 16'shFFD2
`define COTM_TRIM_MAX 16'sh001E
`define COTM_MH_MIN 16'shFFA4
`define COTM_MH_MAX 16'sh001E
`define COTM_ML_MIN 16'shFFC3
`define COTM_ML_MAX 16'sh0000
// reference code: nominal 600 mV in units of 2^-9/5 V
`define COTM_REF_NOM 16'sh0600
`define COTM_REF_SCALE 16'sh0005
// status bit positions
`define COTM_STB_CML 1
`define COTM_CML_INVAL 7
`endif

// ==== cotm_pkg.sv ====
// types shared by the converter control block
`default_nettype none
package cotm_pkg;
  typedef enum logic [1:0] {MRG_OFF, MRG_LOW, MRG_HIGH} cotm_margin_t;
  typedef enum logic {OUT_OFF, OUT_ON} cotm_out_t;
endpackage : cotm_pkg
`default_nettype wire

// ==== cotm_pin_sync.sv ====
// two-flop synchronisers for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module cotm_pin_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins in, synchronised levels out
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinSync
);
  if (W < 1) begin : g_chk
    $error("cotm_pin_sync: W must be at least 1");
  end

  // one pair of flops per pin; the first flop feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_r, meta_nxt, hold_r, hold_nxt;
    always_comb begin
      meta_nxt = pinIn[i];
      hold_nxt = meta_r;
    end
    always_ff @(posedge core_clk) begin
      if (rst) begin
        meta_r <= 1'b0;
        hold_r <= 1'b0;
      end else begin
        meta_r <= meta_nxt;
        hold_r <= hold_nxt;
      end
    end
    assign pinSync[i] = hold_r;
  end
endmodule : cotm_pin_sync
`default_nettype wire

// ==== cotm_ref_calc.sv ====
// internal reference computation from trim and margin steps
`timescale 1ns/100ps
`default_nettype none
`include "cotm_consts.svh"
module cotm_ref_calc #(
  parameter int TRIM_W = 7,
  parameter int REF_W = 12
) (
  // settings
  input wire cotm_pkg::cotm_margin_t margin,
  input wire logic signed [TRIM_W-1:0] trim,
  input wire logic [15:0] stepHigh,
  input wire logic [15:0] stepLow,
  input wire logic lowVout,
  // reference code, units of 2^-9/5 V
  output logic [REF_W-1:0] refCode
);
  if (TRIM_W < 7 || TRIM_W > 10 || REF_W < 11 || REF_W > 16) begin : g_chk
    $error("cotm_ref_calc: unsupported width");
  end

  logic signed [15:0] step, net, lo, hi, clamped, sum;

  // only the reference moves; the divider is never touched
  always_comb begin
    step = 16'sh0000;
    lo = `COTM_TRIM_MIN;
    hi = `COTM_TRIM_MAX;
    case (margin)
      cotm_pkg::MRG_HIGH: begin
        step = {stepHigh[`COTM_STEP_SIGN], stepHigh[14:0]};
        lo = `COTM_MH_MIN;
        hi = `COTM_MH_MAX;
      end
      cotm_pkg::MRG_LOW: begin
        step = {stepLow[`COTM_STEP_SIGN], stepLow[14:0]};
        lo = `COTM_ML_MIN;
        hi = `COTM_ML_MAX;
      end
      default: ;
    endcase
    // floor for the lowest output setting keeps the output above its minimum
    if (lowVout && lo < `COTM_TRIM_MIN_LV) begin
      lo = `COTM_TRIM_MIN_LV;
    end
    net = step + 16'(trim);
    clamped = (net < lo) ? lo : ((net > hi) ? hi : net);
    sum = `COTM_REF_NOM + 16'(clamped * `COTM_REF_SCALE);
    refCode = sum[REF_W-1:0];
  end
endmodule : cotm_ref_calc
`default_nettype wire

// ==== cotm_ctrl.sv ====
// converter on/off, soft-start, trim and margin control (top)
`timescale 1ns/100ps
`default_nettype none
`include "cotm_consts.svh"
module cotm_ctrl #(
  parameter int TRIM_W = 7,
  parameter int REF_W = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // asynchronous pins
  input wire logic remoteEnablePin,
  input wire logic inputPowerOk,
  input wire logic lowVoutStrap,
  // decoded command writes, checksum already verified upstream
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdData,
  // readback
  input wire logic [7:0] rdCode,
  output logic [15:0] rdData,
  // converter controls
  output logic outputEnable,
  output logic [REF_W-1:0] refCode,
  output logic [2:0] riseSel,
  // alert, open drain
  output logic smbAlertOut,
  output logic smbAlertOe
);
  if (TRIM_W < 7 || TRIM_W > 10 || REF_W < 11 || REF_W > 16) begin : g_chk
    $error("cotm_ctrl: unsupported width");
  end

  localparam logic [10:0] RISE_TAB [8] = '{`COTM_RISE_M0, `COTM_RISE_M1,
    `COTM_RISE_M2, `COTM_RISE_M3, `COTM_RISE_M4, `COTM_RISE_M5,
    `COTM_RISE_M6, `COTM_RISE_M7};

  logic [7:0] op_r, op_nxt;
  logic [4:0] cfg_r, cfg_nxt;
  logic signed [TRIM_W-1:0] trim_r, trim_nxt;
  logic [15:0] mHigh_r, mHigh_nxt, mLow_r, mLow_nxt;
  logic [2:0] rise_r, rise_nxt;
  logic cml_r, cml_nxt, inval_r, inval_nxt;
  cotm_pkg::cotm_out_t out_r, out_nxt;
  logic [REF_W-1:0] ref_r, ref_nxt, refCalc;
  logic [15:0] rd_r, rd_nxt;
  logic trimBad, riseBad, riseHit, pinAsserted, wantOn;
  logic [1:0] syncIn, syncOut;
  logic pinS, pwrS, lowVS;
  logic signed [15:0] trimIn;
  logic [7:0] stByte, stCml;
  cotm_pkg::cotm_margin_t mrg;

  // pin levels cross into the core clock here
  assign syncIn = {inputPowerOk, remoteEnablePin};
  cotm_pin_sync #(.W(2)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(syncIn),
    .pinSync(syncOut)
  );
  assign pinS = syncOut[0];
  assign pwrS = syncOut[1];

  // strap is a slow level but still from outside, so it is synchronised too
  cotm_pin_sync #(.W(1)) u_strap (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(lowVoutStrap),
    .pinSync(lowVS)
  );

  // command writes update the settings
  always_comb begin
    op_nxt = op_r;
    cfg_nxt = cfg_r;
    trim_nxt = trim_r;
    mHigh_nxt = mHigh_r;
    mLow_nxt = mLow_r;
    rise_nxt = rise_r;
    trimBad = 1'b0;
    riseBad = 1'b0;
    riseHit = 1'b0;
    trimIn = {{5{cmdData[`COTM_MANT_HI]}}, cmdData[`COTM_MANT_HI:0]};
    if (cmdWrite) begin
      case (cmdCode)
        `COTM_CMD_OPERATION: op_nxt = cmdData[7:0];
        // read-only bit keeps its value whatever the host sends
        `COTM_CMD_ONOFF: cfg_nxt = (cfg_r & ~`COTM_CFG_WMASK)
            | (cmdData[4:0] & `COTM_CFG_WMASK);
        `COTM_CMD_RISE: begin
          for (int i = 0; i < 8; i++) begin
            if (cmdData[`COTM_MANT_HI:0] == RISE_TAB[i]) begin
              rise_nxt = 3'(i);
              riseHit = 1'b1;
            end
          end
          // wrong exponent or an unlisted mantissa leaves the old choice
          if (cmdData[`COTM_EXP_HI:`COTM_EXP_LO] != `COTM_EXP_RISE || !riseHit) begin
            rise_nxt = rise_r;
            riseBad = 1'b1;
          end
        end
        `COTM_CMD_TRIM: begin
          if (cmdData[`COTM_EXP_HI:`COTM_EXP_LO] != `COTM_EXP_M9) begin
            trimBad = 1'b1;
          end else if (trimIn < (lowVS ? `COTM_TRIM_MIN_LV : `COTM_TRIM_MIN)) begin
            trim_nxt = lowVS ? TRIM_W'(`COTM_TRIM_MIN_LV) : TRIM_W'(`COTM_TRIM_MIN);
            trimBad = 1'b1;
          end else if (trimIn > `COTM_TRIM_MAX) begin
            trim_nxt = TRIM_W'(`COTM_TRIM_MAX);
            trimBad = 1'b1;
          end else begin
            trim_nxt = TRIM_W'(trimIn);
          end
        end
        `COTM_CMD_MHIGH: mHigh_nxt = {1'b0, cmdData[14:0]};
        `COTM_CMD_MLOW: mLow_nxt = {1'b0, cmdData[14:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_r <= `COTM_OP_RST;
      cfg_r <= `COTM_CFG_RST;
      trim_r <= '0;
      mHigh_r <= 16'h0000;
      mLow_r <= 16'h0000;
      rise_r <= 3'h0;
    end else begin
      op_r <= op_nxt;
      cfg_r <= cfg_nxt;
      trim_r <= trim_nxt;
      mHigh_r <= mHigh_nxt;
      mLow_r <= mLow_nxt;
      rise_r <= rise_nxt;
    end
  end

  // sticky fault flags; a new fault in the clearing cycle still sets
  always_comb begin
    cml_nxt = cml_r;
    inval_nxt = inval_r;
    if (cmdWrite && cmdCode == `COTM_CMD_CLEAR) begin
      cml_nxt = 1'b0;
      inval_nxt = 1'b0;
    end
    if (trimBad || riseBad) begin
      cml_nxt = 1'b1;
      inval_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cml_r <= 1'b0;
      inval_r <= 1'b0;
    end else begin
      cml_r <= cml_nxt;
      inval_r <= inval_nxt;
    end
  end

  // margin mode from operation bits 5:2; unlisted codes run unmargined
  always_comb begin
    case (op_r[`COTM_OP_MRG_HI:`COTM_OP_MRG_LO])
      `COTM_MRG_LOW_A, `COTM_MRG_LOW_B: mrg = cotm_pkg::MRG_LOW;
      `COTM_MRG_HIGH_A, `COTM_MRG_HIGH_B: mrg = cotm_pkg::MRG_HIGH;
      default: mrg = cotm_pkg::MRG_OFF;
    endcase
  end

  cotm_ref_calc #(.TRIM_W(TRIM_W), .REF_W(REF_W)) u_ref (
    .margin(mrg),
    .trim(trim_r),
    .stepHigh(mHigh_r),
    .stepLow(mLow_r),
    .lowVout(lowVS),
    .refCode(refCalc)
  );

  // on/off decision from policy, pin and command
  assign pinAsserted = cfg_r[`COTM_CFG_PINPOL] ? pinS : ~pinS;
  assign wantOn = pwrS && (!cfg_r[`COTM_CFG_PWRUP]
    || ((!cfg_r[`COTM_CFG_PINRSP] || pinAsserted)
    && (!cfg_r[`COTM_CFG_CMDRSP] || op_r[`COTM_OP_ON])));

  // status views for readback
  always_comb begin
    stByte = 8'h00;
    stCml = 8'h00;
    stByte[`COTM_STB_CML] = cml_r;
    stCml[`COTM_CML_INVAL] = inval_r;
  end

  // output state, reference and readback data
  always_comb begin
    case (out_r)
      cotm_pkg::OUT_OFF: out_nxt = wantOn ? cotm_pkg::OUT_ON : cotm_pkg::OUT_OFF;
      cotm_pkg::OUT_ON: out_nxt = wantOn ? cotm_pkg::OUT_ON : cotm_pkg::OUT_OFF;
      default: out_nxt = cotm_pkg::OUT_OFF;
    endcase
    ref_nxt = refCalc;
    case (rdCode)
      `COTM_CMD_OPERATION: rd_nxt = {8'h00, op_r};
      `COTM_CMD_ONOFF: rd_nxt = {11'h000, cfg_r};
      `COTM_CMD_RISE: rd_nxt = {`COTM_EXP_RISE, RISE_TAB[rise_r]};
      `COTM_CMD_TRIM: rd_nxt = {`COTM_EXP_M9, 11'(trim_r)};
      `COTM_CMD_MHIGH: rd_nxt = mHigh_r;
      `COTM_CMD_MLOW: rd_nxt = mLow_r;
      `COTM_CMD_STATUS: rd_nxt = {8'h00, stByte};
      `COTM_CMD_STCML: rd_nxt = {8'h00, stCml};
      default: rd_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_r <= cotm_pkg::OUT_OFF;
      ref_r <= REF_W'(`COTM_REF_NOM);
      rd_r <= 16'h0000;
    end else begin
      out_r <= out_nxt;
      ref_r <= ref_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign outputEnable = (out_r == cotm_pkg::OUT_ON);
  assign refCode = ref_r;
  assign riseSel = rise_r;
  assign rdData = rd_r;
  assign smbAlertOut = 1'b0;
  assign smbAlertOe = cml_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_cfg_ro;
    cfg_r[`COTM_CFG_PINOFF] == 1'b0;
  endproperty
  a_cfg_ro: assert property (p_cfg_ro) else $error("pin off action bit changed");

  property p_policy0;
    (!cfg_r[`COTM_CFG_PWRUP] && pwrS) |=> outputEnable;
  endproperty
  a_policy0: assert property (p_policy0) else $error("policy 0 output not on");

  property p_pin_off;
    (cfg_r[`COTM_CFG_PWRUP] && cfg_r[`COTM_CFG_PINRSP] && !pinAsserted) |=> !outputEnable;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("output on without pin");

  property p_cmd_off;
    (cfg_r[`COTM_CFG_PWRUP] && cfg_r[`COTM_CFG_CMDRSP] && !op_r[`COTM_OP_ON])
      |=> !outputEnable;
  endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("output on without command");

  property p_ignore_both;
    (pwrS && cfg_r[`COTM_CFG_PWRUP] && !cfg_r[`COTM_CFG_CMDRSP]
      && !cfg_r[`COTM_CFG_PINRSP]) |=> outputEnable;
  endproperty
  a_ignore_both: assert property (p_ignore_both) else $error("ignored sources held off");

  // a word with the wrong exponent is ignored, not clamped
  property p_trim_alert;
    (cmdWrite && cmdCode == `COTM_CMD_TRIM && trimIn > `COTM_TRIM_MAX
      && cmdData[`COTM_EXP_HI:`COTM_EXP_LO] == `COTM_EXP_M9)
      |=> (trim_r == TRIM_W'(`COTM_TRIM_MAX)) && smbAlertOe && inval_r;
  endproperty
  a_trim_alert: assert property (p_trim_alert) else $error("bad trim not clamped");

  property p_trim_range;
    (16'(trim_r) >= `COTM_TRIM_MIN) && (16'(trim_r) <= `COTM_TRIM_MAX);
  endproperty
  a_trim_range: assert property (p_trim_range) else $error("trim outside range");

  property p_margin_low;
    (cmdWrite && cmdCode == `COTM_CMD_OPERATION && cmdData[5:2] == `COTM_MRG_LOW_A)
      |=> mrg == cotm_pkg::MRG_LOW;
  endproperty
  a_margin_low: assert property (p_margin_low) else $error("margin low not selected");

  property p_ref_nom;
    (mrg == cotm_pkg::MRG_OFF && !lowVS && $stable(trim_r))
      |=> refCode == REF_W'(`COTM_REF_NOM + 16'($past(trim_r) * `COTM_REF_SCALE));
  endproperty
  a_ref_nom: assert property (p_ref_nom) else $error("reference not nominal plus trim");

  property p_rise;
    (cmdWrite && cmdCode == `COTM_CMD_RISE && cmdData == {`COTM_EXP_RISE, `COTM_RISE_M7})
      |=> riseSel == 3'h7;
  endproperty
  a_rise: assert property (p_rise) else $error("rise time not taken");
endmodule : cotm_ctrl
`default_nettype wire

// ==== cotm_host_model.sv ====
// host-side model that issues decoded command writes to the control block
`timescale 1ns/100ps
`default_nettype none
module cotm_host_model (
  // clock
  input wire logic core_clk,
  // decoded command port
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [15:0] cmdData
);
  // idle port at time zero
  initial begin
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdData = 16'h0000;
  end

  // linear word: exponent above an 11-bit mantissa
  function automatic logic [15:0] linWord(input logic [4:0] e, input logic [10:0] m);
    return {e, m};
  endfunction : linWord

  // one write, optionally after idle cycles; packet check already settled on the link
  task automatic send(input logic [7:0] code, input logic [15:0] data, input int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    cmdWrite <= 1'b1;
    cmdCode <= code;
    cmdData <= data;
    @(posedge core_clk);
    cmdWrite <= 1'b0;
    // released lines show the inverse so a stale value cannot pass for a held one
    cmdCode <= ~code;
    cmdData <= ~data;
  endtask : send
endmodule : cotm_host_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the converter on/off, trim and margin control
`timescale 1ns/100ps
`default_nettype none
`include "cotm_consts.svh"
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic remoteEnablePin = 1'b0;
  logic inputPowerOk = 1'b1;
  logic lowVoutStrap = 1'b0;
  logic [7:0] rdCode = 8'h00;
  logic cmdWrite;
  logic [7:0] cmdCode;
  logic [15:0] cmdData;
  logic [15:0] rdData;
  logic outputEnable;
  logic [11:0] refCode;
  logic [2:0] riseSel;
  logic smbAlertOut;
  logic smbAlertOe;
  logic [15:0] rv;
  int badCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  // alert line with its pull-up
  wire alertLine = smbAlertOe ? smbAlertOut : 1'b1;

  cotm_ctrl dut (
    .core_clk(core_clk), .rst(rst), .remoteEnablePin(remoteEnablePin),
    .inputPowerOk(inputPowerOk), .lowVoutStrap(lowVoutStrap), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdData(cmdData), .rdCode(rdCode), .rdData(rdData),
    .outputEnable(outputEnable), .refCode(refCode), .riseSel(riseSel),
    .smbAlertOut(smbAlertOut), .smbAlertOe(smbAlertOe)
  );
  cotm_host_model host (
    .core_clk(core_clk), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData)
  );

  // 250 MHz clock
  always #2 core_clk = ~core_clk;

  // hang guard, well above the thousand or so cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      badCount++;
      $display("[FAIL] %0t timeout", $time);
      finalReport();
    end
  end

  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chkVal

  task automatic chkBit(input logic got, input logic exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chkBit

  task automatic waitClk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : waitClk

  // readback answers one edge after the code is taken
  task automatic rd(input logic [7:0] code);
    @(posedge core_clk);
    rdCode <= code;
    waitClk(2);
    rv = rdData;
  endtask : rd

  // expected enable from config, command bit and pin, with input power good
  function automatic logic expOn(input logic [4:0] c, input logic op7, input logic pin);
    logic asserted;
    asserted = c[1] ? pin : ~pin;
    return !c[4] || ((!c[2] || asserted) && (!c[3] || op7));
  endfunction : expOn

  task automatic tReset();
    waitClk(4);
    chkBit(outputEnable, 1'b0, "off during reset");
    repeat (3) @(posedge core_clk);
    @(posedge core_clk);
    rst <= 1'b0;
    waitClk(4);
    chkBit(outputEnable, 1'b1, "default on");
    chkVal({4'h0, refCode}, 16'h0600, "nominal ref");
    chkVal({13'h0000, riseSel}, 16'h0000, "rise default");
    rd(`COTM_CMD_ONOFF);
    chkVal(rv, 16'h0014, "config default");
    rd(`COTM_CMD_OPERATION);
    chkVal(rv, 16'h0080, "operation default");
    rd(8'h55);
    chkVal(rv, 16'h0000, "unmapped read");
    // writes to the read-only bit and the unused bits leave them untouched
    host.send(`COTM_CMD_ONOFF, 16'h00FF, 0);
    rd(`COTM_CMD_ONOFF);
    chkVal(rv, 16'h001E, "config mask");
    $display("test reset_config done");
  endtask : tReset

  task automatic tEnable();
    logic [4:0] c;
    for (int i = 0; i < 64; i++) begin
      c = {i[3:0], 1'b0};
      host.send(`COTM_CMD_ONOFF, {11'h000, c}, 0);
      host.send(`COTM_CMD_OPERATION, {8'h00, i[4], 7'h00}, i % 3);
      @(posedge core_clk);
      remoteEnablePin <= i[5];
      waitClk(6);
      chkBit(outputEnable, expOn(c, i[4], i[5]), "enable");
    end
    @(posedge core_clk);
    inputPowerOk <= 1'b0;
    waitClk(6);
    chkBit(outputEnable, 1'b0, "no input power");
    host.send(`COTM_CMD_ONOFF, 16'h0000, 0);
    waitClk(6);
    chkBit(outputEnable, 1'b0, "no power policy 0");
    @(posedge core_clk);
    inputPowerOk <= 1'b1;
    waitClk(6);
    chkBit(outputEnable, 1'b1, "policy 0 on");
    $display("test enable done");
  endtask : tEnable

  task automatic tRise();
    logic [10:0] mt [8];
    mt = '{11'h00A, 11'h00E, 11'h013, 11'h01D, 11'h02B, 11'h043, 11'h060, 11'h090};
    for (int i = 0; i < 8; i++) begin
      host.send(`COTM_CMD_RISE, host.linWord(5'h1C, mt[i]), 0);
      waitClk(3);
      chkVal({13'h0000, riseSel}, 16'(i), "rise choice");
    end
    host.send(`COTM_CMD_RISE, host.linWord(5'h1C, 11'h00B), 0);
    host.send(`COTM_CMD_RISE, host.linWord(5'h1B, 11'h00A), 0);
    waitClk(3);
    chkVal({13'h0000, riseSel}, 16'h0007, "bad rise kept");
    chkBit(alertLine, 1'b0, "bad rise alert");
    rd(`COTM_CMD_RISE);
    chkVal(rv, 16'hE090, "rise readback");
    host.send(`COTM_CMD_CLEAR, 16'h0000, 0);
    waitClk(3);
    chkBit(alertLine, 1'b1, "alert cleared");
    $display("test rise done");
  endtask : tRise

  task automatic tTrim();
    host.send(`COTM_CMD_TRIM, host.linWord(5'h18, 11'h005), 0);
    waitClk(3);
    chkVal({4'h0, refCode}, 16'h0600, "wrong exponent ignored");
    host.send(`COTM_CMD_TRIM, host.linWord(5'h17, 11'h01F), 0);
    waitClk(3);
    chkVal({4'h0, refCode}, 16'h0696, "trim upper clamp");
    chkBit(alertLine, 1'b0, "clamp alert");
    rd(`COTM_CMD_STATUS);
    chkBit(rv[1], 1'b1, "status cml flag");
    rd(`COTM_CMD_STCML);
    chkBit(rv[7], 1'b1, "invalid data flag");
    host.send(`COTM_CMD_CLEAR, 16'h0000, 0);
    @(posedge core_clk);
    lowVoutStrap <= 1'b1;
    waitClk(4);
    host.send(`COTM_CMD_TRIM, host.linWord(5'h17, 11'h7C4), 0);
    waitClk(3);
    chkVal({4'h0, refCode}, 16'h051A, "low output floor");
    chkBit(alertLine, 1'b0, "floor alert");
    host.send(`COTM_CMD_CLEAR, 16'h0000, 0);
    @(posedge core_clk);
    lowVoutStrap <= 1'b0;
    waitClk(4);
    host.send(`COTM_CMD_TRIM, host.linWord(5'h17, 11'h7FD), 0);
    waitClk(3);
    chkVal({4'h0, refCode}, 16'h05F1, "trim minus three");
    chkBit(alertLine, 1'b1, "no alert in range");
    rd(`COTM_CMD_TRIM);
    chkVal(rv, 16'hBFFD, "trim readback");
    $display("test trim done");
  endtask : tTrim

  task automatic tMargin();
    logic [7:0] ops [6];
    logic [15:0] refs [6];
    ops = '{8'h94, 8'h98, 8'hA4, 8'hA8, 8'h83, 8'hBC};
    refs = '{16'h05AB, 16'h05AB, 16'h0673, 16'h0673, 16'h05F1, 16'h05F1};
    host.send(`COTM_CMD_MLOW, 16'h7FF2, 0);
    // top bit set on purpose: the step must come back with it cleared
    host.send(`COTM_CMD_MHIGH, 16'h801A, 2);
    rd(`COTM_CMD_MHIGH);
    chkVal(rv, 16'h001A, "margin high top bit");
    rd(`COTM_CMD_MLOW);
    chkVal(rv, 16'h7FF2, "margin low readback");
    for (int i = 0; i < 6; i++) begin
      host.send(`COTM_CMD_OPERATION, {8'h00, ops[i]}, 0);
      waitClk(3);
      chkVal({4'h0, refCode}, refs[i], "margin ref");
    end
    host.send(`COTM_CMD_MHIGH, 16'h0064, 0);
    host.send(`COTM_CMD_OPERATION, 16'h00A4, 0);
    waitClk(3);
    chkVal({4'h0, refCode}, 16'h0696, "margin high clamp");
    host.send(`COTM_CMD_MLOW, 16'h0014, 0);
    host.send(`COTM_CMD_OPERATION, 16'h0094, 0);
    waitClk(3);
    chkVal({4'h0, refCode}, 16'h0600, "margin low ceiling");
    chkBit(outputEnable, 1'b1, "stays on while margined");
    $display("test margin done");
  endtask : tMargin

  task automatic finalReport();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finalReport

  // main sequence
  initial begin
    tReset();
    tEnable();
    tRise();
    tTrim();
    tMargin();
    finalReport();
  end
endmodule : tb
`default_nettype wire
